// [ddrpc_pkg.sv]
// Shared constants for the DDR2 pin command and data interface block.
package ddrpc_pkg;
    // Command codes on {rowStrobe_n, colStrobe_n, writeEnable_n}.
    localparam logic [2:0] CMD_MODE_SET  = 3'h0;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_READ      = 3'h5;
    localparam logic [2:0] CMD_TERMINATE = 3'h6;
    localparam logic [2:0] CMD_NOP       = 3'h7;

    // Mode register selected by bank_select during a mode set.
    localparam logic [2:0] SEL_BASE_MODE = 3'h0;
    localparam logic [2:0] SEL_EXT_ONE   = 3'h1;

    // Field positions in the command address, the base mode register and extended register one.
    localparam int BURST_LSB          = 0;
    localparam int AUTO_PRECHARGE_BIT = 10;
    localparam int TERM_SEL_LOW_BIT   = 2;
    localparam int TERM_SEL_HIGH_BIT  = 6;
    localparam int COMP_STROBE_BIT    = 10;
    localparam int REDUNDANT_BIT      = 11;

    // Burst length codes and beat counts.
    localparam logic [2:0] BURST_CODE_4 = 3'h2;
    localparam logic [2:0] BURST_CODE_8 = 3'h3;
    localparam logic [3:0] BEATS_4      = 4'h4;
    localparam logic [3:0] BEATS_8      = 4'h8;

    // Reset values of the mode registers.
    localparam logic [14:0] BASE_MODE_RESET = 15'h0002;
    localparam logic [14:0] EXT_ONE_RESET   = 15'h0000;

    // Column field width and synchroniser depth.
    localparam int COLUMN_BITS = 10;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        DDRPC_IDLE,
        DDRPC_WRITE,
        DDRPC_READ
    } ddrpc_state_t;
endpackage

// [ddrpc_core.sv]
// DDR2 device pin command decoder, mode registers and data path.
`timescale 1ns/1ns

// Small flip-flop FIFO with valid and ready on both sides.
module ddrpc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("FIFO depth must be a power of two of at least two.");
        end
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;
    wire              pushing = inValid && inReady;
    wire              popping = outValid && outReady;

    assign inReady  = (wrPtr - rdPtr) != (AW + 1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign outData  = store[rdPtr[AW-1:0]];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (pushing) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (popping) begin
                rdPtr <= rdPtr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (pushing) begin
            store[wrPtr[AW-1:0]] <= inData;
        end
    end
endmodule // ddrpc_fifo

module ddrpc_core #(
    parameter int DATA_WIDTH = 8,
    parameter int ADDR_WIDTH = 15,
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Link clock and command pins
    input  wire logic                  linkClock,
    input  wire logic                  clockGate,
    input  wire logic                  chipSelect_n,
    input  wire logic                  rowStrobe_n,
    input  wire logic                  colStrobe_n,
    input  wire logic                  writeEnable_n,
    input  wire logic [2:0]            bank_select,
    input  wire logic [ADDR_WIDTH-1:0] address_in,
    input  wire logic                  die_termination_ctl,
    // Data, mask and strobe pins, one strobe and mask per byte lane
    input  wire logic [DATA_WIDTH-1:0] dataIn,
    output logic      [DATA_WIDTH-1:0] dataOut,
    output logic                       dataOe,
    input  wire logic [DATA_WIDTH/8-1:0] write_mask,
    input  wire logic [DATA_WIDTH/8-1:0] strobeIn,
    output logic      [DATA_WIDTH/8-1:0] strobeOut,
    output logic      [DATA_WIDTH/8-1:0] strobeOutN,
    output logic      [DATA_WIDTH/8-1:0] strobeOe,
    output logic      [DATA_WIDTH/8-1:0] strobeOeN,
    output logic                       redundant_read_strobe,
    output logic                       redundantStrobeN,
    output logic                       redundantOe,
    // Termination and mode status
    output logic                       terminationOn,
    output logic                       compStrobeEnable,
    output logic                       writeMaskEnable,
    output logic      [14:0]           baseModeReg,
    output logic      [14:0]           extended_mode_reg_one,
    // Decoded array commands
    output logic                       activatePulse,
    output logic                       readPulse,
    output logic                       writePulse,
    output logic                       prechargePulse,
    output logic                       prechargeAll,
    output logic      [2:0]            cmdBank,
    output logic      [ADDR_WIDTH-1:0] cmdRow,
    output logic      [9:0]            cmdColumn,
    output logic                       cmdAutoPrecharge,
    // Received write beats to the user
    output logic                       wrBeatValid,
    input  wire logic                  wrBeatReady,
    output logic      [DATA_WIDTH-1:0] wrBeatData,
    output logic      [DATA_WIDTH/8-1:0] wrBeatMask,
    output logic                       wrBufferReady,
    // Read beats from the user
    input  wire logic                  rdBeatValid,
    output logic                       rdBeatReady,
    input  wire logic [DATA_WIDTH-1:0] rdBeatData
);
    localparam int LANES = DATA_WIDTH / 8;
    localparam int PW    = 10 + ADDR_WIDTH + DATA_WIDTH + 2 * LANES;
    localparam bit BYTE_WIDE = (LANES == 1);

    initial begin
        if (DATA_WIDTH != 8 && DATA_WIDTH != 16) begin
            $error("Data width must be 8 or 16.");
        end
        if (ADDR_WIDTH < 12 || ADDR_WIDTH > 15) begin
            $error("Address width must lie between 12 and 15.");
        end
    end

    function automatic logic [3:0] burstBeats(input logic [2:0] code);
        burstBeats = (code == ddrpc_pkg::BURST_CODE_8) ?
                     ddrpc_pkg::BEATS_8 : ddrpc_pkg::BEATS_4;
    endfunction

    // Every pin passes two flip-flops before any logic reads it.
    wire [PW-1:0] pinBus = {linkClock, clockGate, chipSelect_n, rowStrobe_n,
                            colStrobe_n, writeEnable_n, bank_select,
                            address_in, die_termination_ctl, dataIn,
                            write_mask, strobeIn};
    logic [PW-1:0] syncA;
    logic [PW-1:0] syncB;
    logic [LANES-1:0] strobeLast;
    logic             linkLast;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            syncA      <= '0;
            syncB      <= '0;
            strobeLast <= '0;
            linkLast   <= 1'b0;
        end else begin
            syncA      <= pinBus;
            syncB      <= syncA;
            strobeLast <= syncB[LANES-1:0];
            linkLast   <= syncB[PW-1];
        end
    end

    wire [LANES-1:0]      sStrobe = syncB[LANES-1:0];
    wire [LANES-1:0]      sMask   = syncB[2*LANES-1:LANES];
    wire [DATA_WIDTH-1:0] sData   = syncB[2*LANES+DATA_WIDTH-1:2*LANES];
    wire                  sTerm   = syncB[2*LANES+DATA_WIDTH];
    wire [ADDR_WIDTH-1:0] sAddr   =
        syncB[2*LANES+DATA_WIDTH+ADDR_WIDTH:2*LANES+DATA_WIDTH+1];
    wire [2:0]            sBank   = syncB[PW-7:PW-9];
    wire [2:0]            sCmd    = syncB[PW-4:PW-6];
    wire                  sCs_n   = syncB[PW-3];
    wire                  sGate   = syncB[PW-2];

    // Commands are taken only at a rising link clock edge with gate high.
    wire linkRise = syncB[PW-1] && !linkLast;
    wire cmdTake  = linkRise && sGate && !sCs_n;
    wire isMode   = cmdTake && sCmd == ddrpc_pkg::CMD_MODE_SET;
    wire isAct    = cmdTake && sCmd == ddrpc_pkg::CMD_ACTIVATE;
    wire isRead   = cmdTake && sCmd == ddrpc_pkg::CMD_READ;
    wire isWrite  = cmdTake && sCmd == ddrpc_pkg::CMD_WRITE;
    wire isPre    = cmdTake && sCmd == ddrpc_pkg::CMD_PRECHARGE;

    // Mode register op codes, routed by bank select.
    wire [14:0] opCode  = 15'(sAddr);
    wire        wrBase  = isMode && sBank == ddrpc_pkg::SEL_BASE_MODE;
    wire        wrExt1  = isMode && sBank == ddrpc_pkg::SEL_EXT_ONE;
    wire [14:0] next_baseModeReg = wrBase ? opCode : baseModeReg;
    wire [14:0] next_extReg      =
        wrExt1 ? opCode : extended_mode_reg_one;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            baseModeReg           <= ddrpc_pkg::BASE_MODE_RESET;
            extended_mode_reg_one <= ddrpc_pkg::EXT_ONE_RESET;
        end else begin
            baseModeReg           <= next_baseModeReg;
            extended_mode_reg_one <= next_extReg;
        end
    end

    // Termination is off in the register when both select bits are zero.
    wire termAllowed =
        extended_mode_reg_one[ddrpc_pkg::TERM_SEL_LOW_BIT] ||
        extended_mode_reg_one[ddrpc_pkg::TERM_SEL_HIGH_BIT];
    wire redundantOn = BYTE_WIDE &&
        extended_mode_reg_one[ddrpc_pkg::REDUNDANT_BIT];
    // A set bit turns the complementary lane strobes off, but not redundantStrobeN.
    assign compStrobeEnable =
        !extended_mode_reg_one[ddrpc_pkg::COMP_STROBE_BIT];
    // On byte-wide parts the mask pin doubles as the redundant strobe.
    assign writeMaskEnable = !redundantOn;

    // Decoded array command fields, each held until the next array command that loads it.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            terminationOn    <= 1'b0;
            activatePulse    <= 1'b0;
            readPulse        <= 1'b0;
            writePulse       <= 1'b0;
            prechargePulse   <= 1'b0;
            prechargeAll     <= 1'b0;
            cmdBank          <= '0;
            cmdRow           <= '0;
            cmdColumn        <= '0;
            cmdAutoPrecharge <= 1'b0;
        end else begin
            terminationOn  <= linkRise ? (sTerm && termAllowed)
                                       : (terminationOn && termAllowed);
            activatePulse  <= isAct;
            readPulse      <= isRead;
            writePulse     <= isWrite;
            prechargePulse <= isPre;
            if (isAct || isRead || isWrite || isPre) begin
                cmdBank <= sBank;
            end
            if (isAct) begin
                cmdRow <= sAddr;
            end
            if (isRead || isWrite) begin
                cmdColumn        <= sAddr[ddrpc_pkg::COLUMN_BITS-1:0];
                cmdAutoPrecharge <= sAddr[ddrpc_pkg::AUTO_PRECHARGE_BIT];
            end
            if (isPre) begin
                prechargeAll <= sAddr[ddrpc_pkg::AUTO_PRECHARGE_BIT];
            end
        end
    end

    // Burst sequencing for the data path.
    ddrpc_pkg::ddrpc_state_t state;
    ddrpc_pkg::ddrpc_state_t next_state;
    logic [3:0] beatCount;
    wire  [3:0] beatsPerBurst =
        burstBeats(baseModeReg[ddrpc_pkg::BURST_LSB+2:ddrpc_pkg::BURST_LSB]);

    // Write beats are caught on either edge of the lowest lane strobe.
    wire strobeEdge = sStrobe[0] != strobeLast[0];
    wire [LANES-1:0] beatMask = writeMaskEnable ? sMask : '0;
    wire wrBeat     = state == ddrpc_pkg::DDRPC_WRITE && strobeEdge;
    // A beat with every lane masked is dropped outright.
    wire wrKeep     = wrBeat && !(&beatMask);
    // Read beats advance one per clock while the user supplies data.
    wire rdBeat     = state == ddrpc_pkg::DDRPC_READ && rdBeatValid;
    wire lastBeat   = (wrBeat || rdBeat) && beatCount == beatsPerBurst - 4'h1;

    assign rdBeatReady = state == ddrpc_pkg::DDRPC_READ;

    always_comb begin
        next_state = state;
        unique case (state)
            ddrpc_pkg::DDRPC_IDLE: begin
                if (isWrite) begin
                    next_state = ddrpc_pkg::DDRPC_WRITE;
                end else if (isRead) begin
                    next_state = ddrpc_pkg::DDRPC_READ;
                end
            end
            ddrpc_pkg::DDRPC_WRITE,
            ddrpc_pkg::DDRPC_READ: begin
                if (lastBeat) begin
                    next_state = ddrpc_pkg::DDRPC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= ddrpc_pkg::DDRPC_IDLE;
            beatCount <= '0;
        end else begin
            state     <= next_state;
            beatCount <= (state == ddrpc_pkg::DDRPC_IDLE) ? 4'h0 :
                         (wrBeat || rdBeat) ? beatCount + 4'h1 : beatCount;
        end
    end

    // Read drive: data and strobe change together so edges line up.
    logic strobeLevel;
    logic driving;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dataOut     <= '0;
            strobeLevel <= 1'b0;
            driving     <= 1'b0;
        end else begin
            driving <= state == ddrpc_pkg::DDRPC_READ;
            if (rdBeat) begin
                dataOut     <= rdBeatData;
                strobeLevel <= !strobeLevel;
            end else if (state != ddrpc_pkg::DDRPC_READ) begin
                strobeLevel <= 1'b0;
            end
        end
    end

    assign dataOe = driving;
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane++) begin : g_lane
            // Every lane strobe copies the one strobe level that times the whole read word.
            assign strobeOut[lane]  = strobeLevel;
            assign strobeOutN[lane] = !strobeLevel;
            assign strobeOe[lane]   = driving;
            assign strobeOeN[lane]  = driving && compStrobeEnable;
        end
    endgenerate
    assign redundant_read_strobe = strobeLevel;
    assign redundantStrobeN      = !strobeLevel;
    assign redundantOe           = driving && redundantOn;

    // Kept write beats go through the buffer; a full buffer is reported.
    ddrpc_fifo #(
        .WIDTH (DATA_WIDTH + LANES),
        .DEPTH (FIFO_DEPTH)
    ) u_wrFifo (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inValid  (wrKeep),
        .inReady  (wrBufferReady),
        .inData   ({beatMask, sData}),
        .outValid (wrBeatValid),
        .outReady (wrBeatReady),
        .outData  ({wrBeatMask, wrBeatData})
    );
endmodule // ddrpc_core

// [ddrpc_core_chk.sv]
// Concurrent pin checks for the DDR2 pin command and data core.
`timescale 1ns/1ns
module ddrpc_core_chk #(
    parameter int DATA_WIDTH = 8
) (
    // Clock, reset and link
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire logic                    linkClock,
    // Command and termination pins
    input wire logic                    clockGate,
    input wire logic                    chipSelect_n,
    input wire logic                    die_termination_ctl,
    // Status and decoded commands
    input wire logic                    terminationOn,
    input wire logic                    compStrobeEnable,
    input wire logic                    writeMaskEnable,
    input wire logic [14:0]             extended_mode_reg_one,
    input wire logic                    activatePulse,
    input wire logic                    readPulse,
    input wire logic                    writePulse,
    input wire logic                    prechargePulse,
    // Data path
    input wire logic                    dataOe,
    input wire logic [DATA_WIDTH/8-1:0] strobeOut,
    input wire logic [DATA_WIDTH/8-1:0] strobeOe,
    input wire logic [DATA_WIDTH/8-1:0] strobeOeN,
    input wire logic                    redundantOe,
    input wire logic                    wrBeatValid,
    input wire logic [DATA_WIDTH/8-1:0] wrBeatMask,
    input wire logic                    rdBeatValid,
    input wire logic                    rdBeatReady
);
    logic [1:0] linkSeen;
    logic [3:0] sinceRise;
    logic       anyPulse;
    logic       termAllowed;
    assign anyPulse = activatePulse | readPulse | writePulse | prechargePulse;
    assign termAllowed = extended_mode_reg_one[2] | extended_mode_reg_one[6];
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            linkSeen  <= 2'h0;
            sinceRise <= 4'hF;
        end else begin
            linkSeen  <= {linkSeen[0], linkClock};
            sinceRise <= (linkSeen == 2'h1) ? 4'h0
                       : sinceRise + {3'h0, sinceRise != 4'hF};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_select_needed: assert property (
        anyPulse |-> !$past(chipSelect_n, 3) && $past(clockGate, 3))
        else $error("Command without select.");
    a_pulse_after_rise: assert property (
        anyPulse |-> sinceRise <= 4'h4)
        else $error("Command off link rise.");
    a_one_command: assert property (
        $onehot0({activatePulse, readPulse, writePulse, prechargePulse}))
        else $error("Two commands at once.");
    a_term_follows: assert property (
        $rose(terminationOn) |->
            $past(die_termination_ctl, 2) || $past(die_termination_ctl, 3))
        else $error("Unrequested termination.");
    a_term_disabled: assert property (
        terminationOn |-> $past(termAllowed))
        else $error("Termination while disabled.");
    a_comp_strobe_bit: assert property (
        compStrobeEnable == !extended_mode_reg_one[10])
        else $error("Bad complement enable.");
    a_comp_pair_oe: assert property (
        strobeOeN == (compStrobeEnable ? strobeOe : '0))
        else $error("Bad complement drive.");
    a_mask_enable_bit: assert property (
        writeMaskEnable == !extended_mode_reg_one[11])
        else $error("Bad mask enable.");
    a_strobe_with_data: assert property (
        strobeOe == (dataOe ? '1 : '0))
        else $error("Strobe and data disagree.");
    a_read_strobe_edge: assert property (
        rdBeatValid && rdBeatReady |=> strobeOut == ~$past(strobeOut))
        else $error("Read beat without edge.");
    a_redundant_gate: assert property (
        redundantOe |-> extended_mode_reg_one[11] && dataOe)
        else $error("Redundant strobe while off.");
    a_masked_dropped: assert property (
        wrBeatValid && writeMaskEnable |-> wrBeatMask != '1)
        else $error("Masked beat delivered.");
endmodule // ddrpc_core_chk

bind ddrpc_core ddrpc_core_chk #(.DATA_WIDTH(DATA_WIDTH)) uChk (.*);

// [ddrpc_ctrl_model.sv]
// Behavioural memory controller that drives the pins of the core.
`timescale 1ns/1ns
module ddrpc_ctrl_model (
    // Clocks
    input  wire logic        clk,
    output logic             linkClock,
    output logic             clockGate,
    // Command pins
    output logic             chipSelect_n,
    output logic             rowStrobe_n,
    output logic             colStrobe_n,
    output logic             writeEnable_n,
    output logic [2:0]       bank_select,
    output logic [14:0]      address_in,
    output logic             die_termination_ctl,
    // Shared data and strobe wires
    input  wire logic [7:0]  dataOut,
    input  wire logic        dataOe,
    input  wire logic [0:0]  strobeOut,
    input  wire logic [0:0]  strobeOe,
    output logic      [7:0]  dataIn,
    output logic      [0:0]  write_mask,
    output logic      [0:0]  strobeIn
);
    logic [7:0] dataDrv = 8'h00;
    logic [0:0] strobeDrv = 1'b0;
    assign dataIn   = dataOe ? dataOut : dataDrv;
    assign strobeIn = strobeOe ? strobeOut : strobeDrv;
    initial begin
        linkClock = 1'b0;
        #7;
        forever #160 linkClock = ~linkClock;
    end
    initial begin
        clockGate = 1'b1;
        {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = 4'hF;
        bank_select = 3'h0;
        address_in = 15'h0;
        die_termination_ctl = 1'b0;
        write_mask = 1'b0;
    end
    task automatic cmd(input logic csN, input logic [2:0] code,
                       input logic [2:0] bank, input logic [14:0] addr);
        @(negedge linkClock);
        @(posedge clk);
        chipSelect_n <= csN;
        {rowStrobe_n, colStrobe_n, writeEnable_n} <= code;
        bank_select <= bank;
        address_in <= addr;
        @(negedge linkClock);
        @(posedge clk);
        {rowStrobe_n, colStrobe_n, writeEnable_n} <= ddrpc_pkg::CMD_NOP;
        address_in <= ~addr;
    endtask
    task automatic beat(input logic [7:0] d, input logic m);
        @(posedge clk);
        dataDrv <= d;
        write_mask <= m;
        repeat (2) @(posedge clk);
        strobeDrv <= ~strobeDrv;
        repeat (2) @(posedge clk);
        dataDrv <= ~d;
        write_mask <= ~m;
    endtask
    task automatic term(input logic v);
        @(posedge clk);
        die_termination_ctl <= v;
    endtask
endmodule // ddrpc_ctrl_model

// [ddr2_pin_command_data_interface_test.sv]
// Self-checking bench for the DDR2 pin command and data core.
`timescale 1ns/1ns
module ddr2_pin_command_data_interface_test;
    // Clock, reset and pins
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        linkClock, clockGate, chipSelect_n, die_termination_ctl;
    logic        rowStrobe_n, colStrobe_n, writeEnable_n;
    logic [2:0]  bank_select, cmdBank;
    logic [14:0] address_in, cmdRow, baseModeReg, extended_mode_reg_one;
    logic [7:0]  dataIn, dataOut, wrBeatData, rdBeatData;
    logic [0:0]  write_mask, strobeIn, strobeOut, strobeOutN, strobeOe;
    logic [0:0]  strobeOeN, wrBeatMask;
    logic        dataOe, redundant_read_strobe, redundantStrobeN, redundantOe;
    logic        terminationOn, compStrobeEnable, writeMaskEnable;
    logic        activatePulse, readPulse, writePulse, prechargePulse;
    logic        prechargeAll, cmdAutoPrecharge, wrBeatValid, wrBeatReady;
    logic        wrBufferReady, rdBeatValid, rdBeatReady;
    logic [9:0]  cmdColumn;
    // Scoreboard
    logic [24:0] noteQ[$];
    logic [0:0]  lastStrobe = 1'b0;
    logic [2:0]  idleCodes[3] = '{ddrpc_pkg::CMD_REFRESH,
                                  ddrpc_pkg::CMD_TERMINATE, ddrpc_pkg::CMD_NOP};
    int          failures = 0;
    int          tests_run = 0;

    ddrpc_core uut (.*);
    ddrpc_ctrl_model uCtl (.*);

    always #20 clk = ~clk;

    wire cmdSeen = activatePulse | readPulse | writePulse | prechargePulse;
    wire wrSeen = wrBeatValid & wrBeatReady;
    wire rdSeen = strobeOut != lastStrobe;
    wire [15:0] field = activatePulse ? {1'b0, cmdRow}
        : prechargePulse ? {15'h0, prechargeAll}
        : {5'h0, cmdAutoPrecharge, cmdColumn};
    wire [24:0] seen = cmdSeen ? {2'h0, activatePulse, readPulse, writePulse,
                                  prechargePulse, cmdBank, field}
        : wrSeen ? {2'h1, 14'h0, wrBeatMask, wrBeatData}
        : {2'h2, 15'h0, dataOut};

    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        lastStrobe <= strobeOut;
        if (!sys_rst && (cmdSeen || wrSeen || rdSeen)) begin
            if (noteQ.size() == 0) begin
                failures++;
                $display("MISMATCH at %0t: unexpected %h", $time, seen);
            end else begin
                chk(seen, noteQ.pop_front());
            end
        end
    end
    task automatic issue(input logic csN, input logic [2:0] code,
                         input logic [2:0] bank, input logic [14:0] addr);
        logic [3:0] kind;
        kind = {code == ddrpc_pkg::CMD_ACTIVATE, code == ddrpc_pkg::CMD_READ,
                code == ddrpc_pkg::CMD_WRITE, code == ddrpc_pkg::CMD_PRECHARGE};
        if (!csN && kind != 4'h0) begin
            noteQ.push_back({2'h0, kind, bank, kind[3] ? {1'b0, addr}
                : kind[0] ? {15'h0, addr[10]} : {5'h0, addr[10:0]}});
        end
        uCtl.cmd(csN, code, bank, addr);
    endtask
    task automatic wrBurst(input int n, input int mBeat, input bit drops);
        logic [7:0] d;
        int kept;
        kept = 0;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (!(drops && i == mBeat) && kept < 4) begin
                noteQ.push_back({2'h1, 15'h0, d});
                kept++;
            end
            uCtl.beat(d, i == mBeat);
        end
    endtask
    task automatic rdBurst;
        logic [7:0] d;
        int n;
        n = 0;
        while (rdBeatReady !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n == 40) begin
            failures++;
            $display("MISMATCH at %0t: no read", $time);
            conclude();
        end
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            noteQ.push_back({2'h2, 15'h0, d});
            rdBeatValid <= 1'b1;
            rdBeatData <= d;
            @(posedge clk);
        end
        rdBeatValid <= 1'b0;
    endtask

    initial begin
        #2000000;
        failures++;
        $display("MISMATCH at %0t: timeout", $time);
        conclude();
    end
    initial begin
        logic [2:0]  bank;
        logic [14:0] addr;
        wrBeatReady = 1'b1;
        rdBeatValid = 1'b0;
        rdBeatData = 8'h00;
        void'($urandom(84));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk({baseModeReg, extended_mode_reg_one[9:0]},
            {ddrpc_pkg::BASE_MODE_RESET, ddrpc_pkg::EXT_ONE_RESET[9:0]});
        chk({compStrobeEnable, writeMaskEnable, wrBufferReady}, 25'h7);
        for (int r = 0; r < 2; r++) begin
            bank = 3'($urandom);
            addr = 15'($urandom);
            issue(1'b0, ddrpc_pkg::CMD_ACTIVATE, bank, addr);
            issue(1'b0, ddrpc_pkg::CMD_WRITE, bank, addr ^ 15'h0400);
            wrBurst(4, r + 1, 1'b1);
            issue(1'b0, ddrpc_pkg::CMD_READ, bank, addr);
            rdBurst();
            issue(1'b0, ddrpc_pkg::CMD_PRECHARGE, bank, 15'(r * 1024));
        end
        issue(1'b1, ddrpc_pkg::CMD_ACTIVATE, 3'h1, 15'h1234);
        issue(1'b1, ddrpc_pkg::CMD_MODE_SET, 3'h0, 15'h0003);
        foreach (idleCodes[i]) issue(1'b0, idleCodes[i], 3'h0, 15'h0);
        issue(1'b0, ddrpc_pkg::CMD_MODE_SET, 3'h2, 15'h0003);
        chk({baseModeReg, extended_mode_reg_one[9:0]}, 25'h0_0800);
        issue(1'b0, ddrpc_pkg::CMD_MODE_SET, ddrpc_pkg::SEL_BASE_MODE,
              15'h0003);
        chk({10'h0, baseModeReg}, 25'h3);
        wrBeatReady <= 1'b0;
        issue(1'b0, ddrpc_pkg::CMD_WRITE, 3'h5, 15'h0010);
        wrBurst(8, 8, 1'b1);
        chk({24'h0, wrBufferReady}, 25'h0);
        wrBeatReady <= 1'b1;
        repeat (8) @(posedge clk);
        chk({24'h0, wrBeatValid}, 25'h0);
        issue(1'b0, ddrpc_pkg::CMD_MODE_SET, ddrpc_pkg::SEL_BASE_MODE,
              15'h0002);
        issue(1'b0, ddrpc_pkg::CMD_MODE_SET, ddrpc_pkg::SEL_EXT_ONE, 15'h0004);
        chk({10'h0, extended_mode_reg_one}, 25'h4);
        for (int v = 1; v >= 0; v--) begin
            uCtl.term(1'(v));
            repeat (20) @(posedge clk);
            chk({24'h0, terminationOn}, 25'(v));
        end
        issue(1'b0, ddrpc_pkg::CMD_MODE_SET, ddrpc_pkg::SEL_EXT_ONE, 15'h0C00);
        uCtl.term(1'b1);
        repeat (20) @(posedge clk);
        chk({terminationOn, compStrobeEnable, writeMaskEnable}, 25'h0);
        issue(1'b0, ddrpc_pkg::CMD_WRITE, 3'h3, 15'h0020);
        wrBurst(4, 2, 1'b0);
        issue(1'b0, ddrpc_pkg::CMD_READ, 3'h3, 15'h0020);
        rdBurst();
        uCtl.term(1'b0);
        repeat (20) @(posedge clk);
        chk(25'(noteQ.size()), 25'h0);
        conclude();
    end
endmodule // ddr2_pin_command_data_interface_test
